/* File: common/lbe_pkg.sv */
package lbe_pkg;
    // ------------------------------------------------------------
    // Register addresses on the device control register bus
    // ------------------------------------------------------------
    localparam logic [9:0] ADDR_ARB_STATUS = 10'h084;
    localparam logic [9:0] ADDR_ARB_EADDR = 10'h086;
    localparam logic [9:0] ADDR_ARB_CTRL = 10'h087;
    localparam logic [9:0] ADDR_BRG_STATUS0 = 10'h0A0;
    localparam logic [9:0] ADDR_BRG_EADDR = 10'h0A2;
    localparam logic [9:0] ADDR_BRG_STATUS1 = 10'h0A4;

    // ------------------------------------------------------------
    // Field positions; bit 0 of a register is the MSB, data[31]
    // ------------------------------------------------------------
    localparam int ACR_MODE_POS = 31;
    localparam int ACR_ORDER_MSB = 30;
    localparam int ACR_HBU_POS = 27;
    localparam int ARB_SLOT_W = 4;
    localparam int ARB_SLOT_TOP = 31;
    localparam int BRG_SLOT_W = 5;
    localparam int BRG_SLOT_TOP = 31;
    localparam int BRG_DMA_SLOT = 1;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [2:0] ORDER_LAST_CODE = 3'h3;
    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_TIMEOUT = 2'h1;
    localparam logic [1:0] ERR_SLAVE = 2'h2;
    localparam int NUM_ARB_MASTERS = 3;
    localparam int NUM_BUS_MASTERS = 4;
    localparam logic [1:0] IDX_DMA = 2'h3;

    typedef enum logic {LBE_FIXED, LBE_FAIR} lbe_mode_e;
endpackage

/* File: rtl/lbe_arbiter_errcap.sv */
module lbe_arbiter_errcap (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic dcr_read,
    input wire logic dcr_write,
    input wire logic [9:0] dcr_abus,
    input wire logic [31:0] dcr_dbus_in,
    output logic dcr_ack,
    output logic [31:0] dcr_dbus_out,
    input wire logic [3:0] bus_req,
    input wire logic [7:0] bus_prio,
    output logic [3:0] bus_gnt,
    input wire logic arb_err_valid,
    input wire logic [1:0] arb_err_master,
    input wire logic arb_err_read,
    input wire logic [31:0] arb_err_addr,
    input wire logic arb_err_lock_f,
    input wire logic arb_err_lock_a,
    input wire logic brg_err_valid,
    input wire logic [1:0] brg_err_master,
    input wire logic [1:0] brg_err_type,
    input wire logic brg_err_read,
    input wire logic [31:0] brg_err_addr,
    input wire logic brg_err_lock_f,
    input wire logic brg_err_lock_a
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_s;

    // Two-flop release of the asynchronous reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_s <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Control bus slave
    // ------------------------------------------------------------
    logic ack_ff;
    logic [31:0] dout_ff;
    logic [31:0] rdata;
    logic sel;
    logic wr_stb;
    logic [31:0] acr_ff;
    logic [11:0] arb_st_ff;
    logic [31:0] arb_ear_ff;
    logic [31:0] brg_ear_ff;
    logic [4:0] brg_fld [4];
    logic [31:0] brg_st0;
    logic [31:0] brg_st1;

    // Map a bridge slot number to its five bits of a status word
    function automatic logic [31:0] brg_place(input logic [4:0] f, input int slot);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[lbe_pkg::BRG_SLOT_TOP - slot * lbe_pkg::BRG_SLOT_W -: lbe_pkg::BRG_SLOT_W] = f;
        return w;
    endfunction

    // Extract a bridge slot from a write word
    function automatic logic [4:0] brg_pick(input logic [31:0] w, input int slot);
        return w[lbe_pkg::BRG_SLOT_TOP - slot * lbe_pkg::BRG_SLOT_W -: lbe_pkg::BRG_SLOT_W];
    endfunction

    assign brg_st0 = brg_place(brg_fld[0], 0) | brg_place(brg_fld[1], 1)
                   | brg_place(brg_fld[2], 2);
    assign brg_st1 = brg_place(brg_fld[3], lbe_pkg::BRG_DMA_SLOT);

    // Address decode and read mux; reserved bits read as zero
    always_comb begin
        sel = 1'b1;
        rdata = 32'h0000_0000;
        if (dcr_abus == lbe_pkg::ADDR_ARB_STATUS) begin
            rdata = {arb_st_ff, 20'h00000};
        end else if (dcr_abus == lbe_pkg::ADDR_ARB_EADDR) begin
            rdata = arb_ear_ff;
        end else if (dcr_abus == lbe_pkg::ADDR_ARB_CTRL) begin
            rdata = acr_ff;
        end else if (dcr_abus == lbe_pkg::ADDR_BRG_STATUS0) begin
            rdata = brg_st0;
        end else if (dcr_abus == lbe_pkg::ADDR_BRG_EADDR) begin
            rdata = brg_ear_ff;
        end else if (dcr_abus == lbe_pkg::ADDR_BRG_STATUS1) begin
            rdata = brg_st1;
        end else begin
            sel = 1'b0;
        end
    end

    assign wr_stb = dcr_write && sel && !ack_ff;
    assign dcr_ack = ack_ff;
    assign dcr_dbus_out = dout_ff;

    // Acknowledge held until the request drops; read data registered
    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ack_ff <= 1'b0;
            dout_ff <= lbe_pkg::RST_WORD;
        end else begin
            ack_ff <= sel && (dcr_read || dcr_write);
            dout_ff <= (sel && dcr_read) ? rdata : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Arbiter control register and arbitration
    // ------------------------------------------------------------
    logic [31:0] nxt_acr;

    // Only the mode, order and utilisation bits are writable
    always_comb begin
        nxt_acr = acr_ff;
        if (wr_stb && dcr_abus == lbe_pkg::ADDR_ARB_CTRL) begin
            nxt_acr = 32'h0000_0000;
            nxt_acr[lbe_pkg::ACR_MODE_POS] = dcr_dbus_in[lbe_pkg::ACR_MODE_POS];
            nxt_acr[lbe_pkg::ACR_ORDER_MSB -: 3] = dcr_dbus_in[lbe_pkg::ACR_ORDER_MSB -: 3];
            nxt_acr[lbe_pkg::ACR_HBU_POS] = dcr_dbus_in[lbe_pkg::ACR_HBU_POS];
        end
    end

    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            acr_ff <= lbe_pkg::RST_WORD;
        end else begin
            acr_ff <= nxt_acr;
        end
    end

    logic [3:0] gnt_ff;
    logic [1:0] last_ff;
    logic [3:0] nxt_gnt;
    logic [1:0] nxt_last;
    lbe_pkg::lbe_mode_e mode;
    logic [2:0] ocode;
    logic [1:0] base;
    logic high_utilization_enable;

    assign mode = lbe_pkg::lbe_mode_e'(acr_ff[lbe_pkg::ACR_MODE_POS]);
    assign ocode = acr_ff[lbe_pkg::ACR_ORDER_MSB -: 3];
    assign high_utilization_enable = acr_ff[lbe_pkg::ACR_HBU_POS];
    assign bus_gnt = gnt_ff;

    // Reserved order codes fall back to the reset order
    assign base = (ocode > lbe_pkg::ORDER_LAST_CODE) ? 2'h0 : ocode[1:0];

    // Pick highest level; equal levels broken by order or by rotation
    always_comb begin
        logic [3:0] best;
        logic [3:0] score;
        logic [1:0] start;
        logic [1:0] rank;
        best = 4'h0;
        score = 4'h0;
        start = (mode == lbe_pkg::LBE_FAIR) ? 2'(last_ff + 2'h1) : base;
        rank = 2'h0;
        nxt_gnt = 4'h0;
        nxt_last = last_ff;
        if (high_utilization_enable || gnt_ff == 4'h0) begin
            for (int i = 0; i < lbe_pkg::NUM_BUS_MASTERS; i++) begin
                rank = 2'(2'(i) - start);
                score = {bus_prio[2*i +: 2], 2'(2'h3 - rank)};
                if (bus_req[i] && (nxt_gnt == 4'h0 || score > best)) begin
                    best = score;
                    nxt_gnt = 4'h1 << i;
                    nxt_last = 2'(i);
                end
            end
        end
    end

    // One-cycle grant; without high utilisation a gap cycle follows
    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            gnt_ff <= 4'h0;
            last_ff <= 2'h3;
        end else begin
            gnt_ff <= nxt_gnt;
            last_ff <= nxt_last;
        end
    end

    // ------------------------------------------------------------
    // Arbiter error status and address
    // ------------------------------------------------------------
    logic [11:0] nxt_arb_st;
    logic any_flk;

    // Master m owns {timeout, read, flk, alk} at bits 11-4m down to 8-4m
    always_comb begin
        logic [3:0] cur;
        cur = 4'h0;
        nxt_arb_st = arb_st_ff;
        if (wr_stb && dcr_abus == lbe_pkg::ADDR_ARB_STATUS) begin
            nxt_arb_st = arb_st_ff & ~dcr_dbus_in[31:20];
        end
        for (int m = 0; m < lbe_pkg::NUM_ARB_MASTERS; m++) begin
            cur = arb_st_ff[11 - m*lbe_pkg::ARB_SLOT_W -: 4];
            if (arb_err_valid && arb_err_master == 2'(m) && !cur[1]) begin
                nxt_arb_st[11 - m*lbe_pkg::ARB_SLOT_W -: 4] =
                    {1'b1, arb_err_read, arb_err_lock_f, arb_err_lock_a};
            end
        end
    end

    assign any_flk = arb_st_ff[9] | arb_st_ff[5] | arb_st_ff[1];

    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            arb_st_ff <= 12'h000;
            arb_ear_ff <= lbe_pkg::RST_WORD;
        end else begin
            arb_st_ff <= nxt_arb_st;
            if (arb_err_valid && !any_flk) begin
                arb_ear_ff <= arb_err_addr;
            end
        end
    end

    // ------------------------------------------------------------
    // Bridge error records
    // ------------------------------------------------------------
    logic any_alk;

    for (genvar g = 0; g < lbe_pkg::NUM_BUS_MASTERS; g++) begin : g_brg
        localparam int SLOT = (g == 3) ? lbe_pkg::BRG_DMA_SLOT : g;
        logic [4:0] clr;
        logic hit;
        assign hit = (g == 3) ? (dcr_abus == lbe_pkg::ADDR_BRG_STATUS1)
                              : (dcr_abus == lbe_pkg::ADDR_BRG_STATUS0);
        assign clr = (wr_stb && hit) ? brg_pick(dcr_dbus_in, SLOT) : 5'h00;
        lbe_brg_slice u_slice (
            .mclk(mclk),
            .rst_n(rst_n_s),
            .cap(brg_err_valid && brg_err_master == 2'(g)),
            .etype(brg_err_type),
            .is_write(!brg_err_read),
            .lock_f(brg_err_lock_f),
            .lock_a(brg_err_lock_a),
            .clr(clr),
            .fld(brg_fld[g])
        );
    end

    assign any_alk = brg_fld[0][0] | brg_fld[1][0] | brg_fld[2][0] | brg_fld[3][0];

    // Bridge address frozen while any address lock stands
    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            brg_ear_ff <= lbe_pkg::RST_WORD;
        end else if (brg_err_valid && !any_alk) begin
            brg_ear_ff <= brg_err_addr;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n_s);

    AST_ONE_GRANT: assert property ($onehot0(gnt_ff))
        else $error("More than one grant");
    AST_GAP_NO_HBU: assert property ((gnt_ff != 4'h0 && !high_utilization_enable) |=> gnt_ff == 4'h0)
        else $error("Back-to-back grant without high utilisation");
    AST_GNT_REQ: assert property ((bus_req != 4'h0 && gnt_ff == 4'h0) |=> gnt_ff != 4'h0)
        else $error("Request with idle bus not granted");
    AST_ARB_EAR_HOLD: assert property (any_flk |=> $stable(arb_ear_ff))
        else $error("Arbiter error address changed while locked");
    AST_ARB_EAR_CAP: assert property ((arb_err_valid && !any_flk) |=>
        arb_ear_ff == $past(arb_err_addr))
        else $error("Arbiter error address not captured");
    AST_ARB_TO_SET: assert property ((arb_err_valid && arb_err_master == 2'h0
        && !arb_st_ff[9]) |=> arb_st_ff[11] && arb_st_ff[10] == $past(arb_err_read))
        else $error("Master 0 timeout not recorded");
    AST_ARB_W1C: assert property ((wr_stb && dcr_abus == lbe_pkg::ADDR_ARB_STATUS
        && dcr_dbus_in[31] && !arb_err_valid) |=> !arb_st_ff[11])
        else $error("Write of one did not clear timeout status");
    AST_BRG_EAR_HOLD: assert property (any_alk |=> $stable(brg_ear_ff))
        else $error("Bridge error address changed while locked");
    AST_BRG_ST1_RSV: assert property (brg_st1[31:27] == 5'h00 && brg_st1[21:0] == 22'h0)
        else $error("Reserved bridge status bits set");
    AST_ACK_DATA: assert property ((dcr_read && sel && !ack_ff) |=>
        ack_ff && dcr_dbus_out == $past(rdata))
        else $error("Read answer wrong");

    COV_FAIR_GRANT: cover property (mode == lbe_pkg::LBE_FAIR && gnt_ff != 4'h0);
    COV_ARB_LOCKED_ERR: cover property (any_flk && arb_err_valid);
    COV_BRG_DMA_ERR: cover property (brg_err_valid && brg_err_master == lbe_pkg::IDX_DMA);
    COV_STATUS_CLEAR: cover property (wr_stb && dcr_abus == lbe_pkg::ADDR_BRG_STATUS0);
endmodule

/* File: rtl/lbe_brg_slice.sv */
// ------------------------------------------------------------
// One master's bridge error record: {err[1:0], write, flk, alk}
// ------------------------------------------------------------
module lbe_brg_slice (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cap,
    input wire logic [1:0] etype,
    input wire logic is_write,
    input wire logic lock_f,
    input wire logic lock_a,
    input wire logic [4:0] clr,
    output logic [4:0] fld
);
    logic [4:0] fld_ff;
    logic [4:0] nxt_fld;
    logic locked;

    assign locked = fld_ff[1] | fld_ff[0];
    assign fld = fld_ff;

    // Capture beats a same-cycle clear; a locked record ignores capture but can still be cleared
    always_comb begin
        nxt_fld = fld_ff & ~clr;
        if (cap && !locked) begin
            nxt_fld = {etype, is_write, lock_f, lock_a};
        end
    end

    // Record register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fld_ff <= 5'h00;
        end else begin
            fld_ff <= nxt_fld;
        end
    end

    AST_SLICE_FROZEN: assert property (@(posedge mclk) disable iff (!rst_n)
        (locked && cap && clr == 5'h00) |=> fld_ff == $past(fld_ff))
        else $error("Locked bridge record was overwritten");
endmodule

/* File: verif/lbe_err_src.sv */
// ------------------------------------------------------------
// Bus masters and error sources on the far side of the block
// ------------------------------------------------------------
module lbe_err_src (
    input wire logic mclk,
    output logic arb_err_valid,
    output logic [1:0] arb_err_master,
    output logic arb_err_read,
    output logic [31:0] arb_err_addr,
    output logic arb_err_lock_f,
    output logic arb_err_lock_a,
    output logic brg_err_valid,
    output logic [1:0] brg_err_master,
    output logic [1:0] brg_err_type,
    output logic brg_err_read,
    output logic [31:0] brg_err_addr,
    output logic brg_err_lock_f,
    output logic brg_err_lock_a,
    output logic [3:0] bus_req,
    output logic [7:0] bus_prio
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle state at time zero
    initial begin
        {arb_err_valid, arb_err_master, arb_err_read, arb_err_lock_f, arb_err_lock_a} = '0;
        {brg_err_valid, brg_err_master, brg_err_type, brg_err_read} = '0;
        {brg_err_lock_f, brg_err_lock_a, bus_req, bus_prio} = '0;
        arb_err_addr = 32'h0;
        brg_err_addr = 32'h0;
    end

    // Requests are levels, changed on the falling edge
    task automatic set_req(input logic [3:0] r, input logic [7:0] p);
        @(negedge mclk);
        bus_req = r;
        bus_prio = p;
    endtask

    // Timeout event: one-cycle pulse; stale qualifiers are inverted after it
    task automatic arb_ev(input logic [1:0] m, input logic rd, input logic [31:0] a,
        input logic lf, input logic la);
        @(negedge mclk);
        {arb_err_valid, arb_err_master, arb_err_read} = {1'b1, m, rd};
        {arb_err_addr, arb_err_lock_f, arb_err_lock_a} = {a, lf, la};
        @(negedge mclk);
        arb_err_valid = 1'b0;
        {arb_err_addr, arb_err_read, arb_err_lock_f, arb_err_lock_a} = ~{a, rd, lf, la};
    endtask

    // Bridge error event: one-cycle pulse with type code
    task automatic brg_ev(input logic [1:0] m, input logic [1:0] t, input logic rd,
        input logic [31:0] a, input logic lf, input logic la);
        @(negedge mclk);
        {brg_err_valid, brg_err_master, brg_err_type, brg_err_read} = {1'b1, m, t, rd};
        {brg_err_addr, brg_err_lock_f, brg_err_lock_a} = {a, lf, la};
        @(negedge mclk);
        brg_err_valid = 1'b0;
        {brg_err_addr, brg_err_read, brg_err_lock_f, brg_err_lock_a} = ~{a, rd, lf, la};
        brg_err_type = ~t;
    endtask
endmodule

/* File: verif/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_b, dcr_read, dcr_write, dcr_ack;
    logic [9:0] dcr_abus;
    logic [31:0] dcr_dbus_in, dcr_dbus_out, arb_err_addr, brg_err_addr, rd;
    logic [3:0] bus_req, bus_gnt;
    logic [7:0] bus_prio;
    logic arb_err_valid, arb_err_read, arb_err_lock_f, arb_err_lock_a;
    logic brg_err_valid, brg_err_read, brg_err_lock_f, brg_err_lock_a;
    logic [1:0] arb_err_master, brg_err_master, brg_err_type;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;

    // ------------------------------------------------------------
    // Clock, design and far side
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    lbe_arbiter_errcap dut (.mclk(mclk), .rst_b(rst_b), .dcr_read(dcr_read),
        .dcr_write(dcr_write), .dcr_abus(dcr_abus), .dcr_dbus_in(dcr_dbus_in),
        .dcr_ack(dcr_ack), .dcr_dbus_out(dcr_dbus_out), .bus_req(bus_req),
        .bus_prio(bus_prio), .bus_gnt(bus_gnt), .arb_err_valid(arb_err_valid),
        .arb_err_master(arb_err_master), .arb_err_read(arb_err_read),
        .arb_err_addr(arb_err_addr), .arb_err_lock_f(arb_err_lock_f),
        .arb_err_lock_a(arb_err_lock_a), .brg_err_valid(brg_err_valid),
        .brg_err_master(brg_err_master), .brg_err_type(brg_err_type),
        .brg_err_read(brg_err_read), .brg_err_addr(brg_err_addr),
        .brg_err_lock_f(brg_err_lock_f), .brg_err_lock_a(brg_err_lock_a));

    lbe_err_src u_src (.mclk(mclk), .arb_err_valid(arb_err_valid),
        .arb_err_master(arb_err_master), .arb_err_read(arb_err_read),
        .arb_err_addr(arb_err_addr), .arb_err_lock_f(arb_err_lock_f),
        .arb_err_lock_a(arb_err_lock_a), .brg_err_valid(brg_err_valid),
        .brg_err_master(brg_err_master), .brg_err_type(brg_err_type),
        .brg_err_read(brg_err_read), .brg_err_addr(brg_err_addr),
        .brg_err_lock_f(brg_err_lock_f), .brg_err_lock_a(brg_err_lock_a),
        .bus_req(bus_req), .bus_prio(bus_prio));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One register access held until acknowledge, released on the next falling edge
    task automatic acc(input logic wr, input logic [9:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(negedge mclk);
        {dcr_read, dcr_write, dcr_abus, dcr_dbus_in} = {~wr, wr, a, wd};
        do begin
            @(negedge mclk);
            n++;
        end while (dcr_ack !== 1'b1 && n < 20);
        rd = dcr_dbus_out;
        if (n >= 20) begin
            chk("no ack", 32'h0, 32'h1);
        end
        {dcr_read, dcr_write, dcr_dbus_in} = {2'b00, ~wd};
        @(negedge mclk);
    endtask

    task automatic rd_chk(input string what, input logic [9:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(what, rd, e);
    endtask

    // Request pattern held for three cycles; grants sampled in the first two
    task automatic gnt_chk(input logic [31:0] c, input logic [3:0] r, input logic [7:0] p,
        input logic [3:0] e1, input logic [3:0] e2);
        acc(1'b1, lbe_pkg::ADDR_ARB_CTRL, c);
        u_src.set_req(r, p);
        @(negedge mclk);
        chk("grant first", {28'h0, bus_gnt}, {28'h0, e1});
        @(negedge mclk);
        chk("grant second", {28'h0, bus_gnt}, {28'h0, e2});
        u_src.set_req(4'h0, p);
        repeat (3) @(negedge mclk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd_chk("arb status", lbe_pkg::ADDR_ARB_STATUS, 32'h0);
        rd_chk("arb addr", lbe_pkg::ADDR_ARB_EADDR, 32'h0);
        rd_chk("arb ctrl", lbe_pkg::ADDR_ARB_CTRL, 32'h0);
        rd_chk("brg status0", lbe_pkg::ADDR_BRG_STATUS0, 32'h0);
        rd_chk("brg addr", lbe_pkg::ADDR_BRG_EADDR, 32'h0);
        rd_chk("brg status1", lbe_pkg::ADDR_BRG_STATUS1, 32'h0);
        @(negedge mclk);
        {dcr_read, dcr_abus} = {1'b1, 10'h1FF};
        repeat (4) @(negedge mclk);
        chk("unmapped ack", {31'h0, dcr_ack}, 32'h0);
        chk("unmapped data", dcr_dbus_out, 32'h0);
        dcr_read = 1'b0;
        repeat (2) @(negedge mclk);
        $display("reset test done");
    endtask

    task automatic t_ctrl();
        acc(1'b1, lbe_pkg::ADDR_ARB_CTRL, 32'hFFFF_FFFF);
        rd_chk("ctrl reserved", lbe_pkg::ADDR_ARB_CTRL, 32'hF800_0000);
        acc(1'b1, lbe_pkg::ADDR_ARB_CTRL, 32'h5000_0000);
        rd_chk("ctrl order", lbe_pkg::ADDR_ARB_CTRL, 32'h5000_0000);
        $display("control test done");
    endtask

    task automatic t_grant();
        logic [3:0] first [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1};
        logic [2:0] code [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
        for (int i = 0; i < 5; i++) begin
            gnt_chk({1'b0, code[i], 28'h0}, 4'hF, 8'hAA, first[i], 4'h0);
        end
        gnt_chk(32'h0800_0000, 4'hF, 8'hAA, 4'h1, 4'h1);
        gnt_chk(32'h0000_0000, 4'hF, 8'hBA, 4'h4, 4'h0);
        gnt_chk(32'h0000_0000, 4'h3, 8'hAA, 4'h1, 4'h0);
        gnt_chk(32'h8800_0000, 4'h3, 8'hAA, 4'h2, 4'h1);
        gnt_chk(32'hA800_0000, 4'h3, 8'hAA, 4'h1, 4'h2);
        $display("grant test done");
    endtask

    task automatic t_arb_err();
        u_src.arb_ev(2'h1, 1'b1, 32'h1234_5678, 1'b1, 1'b1);
        rd_chk("arb capture", lbe_pkg::ADDR_ARB_STATUS, 32'h0F00_0000);
        rd_chk("arb addr", lbe_pkg::ADDR_ARB_EADDR, 32'h1234_5678);
        u_src.arb_ev(2'h1, 1'b0, 32'hCAFE_0004, 1'b0, 1'b0);
        rd_chk("arb locked", lbe_pkg::ADDR_ARB_STATUS, 32'h0F00_0000);
        u_src.arb_ev(2'h0, 1'b0, 32'h0000_0100, 1'b0, 1'b0);
        rd_chk("arb write dir", lbe_pkg::ADDR_ARB_STATUS, 32'h8F00_0000);
        rd_chk("arb addr frozen", lbe_pkg::ADDR_ARB_EADDR, 32'h1234_5678);
        acc(1'b1, lbe_pkg::ADDR_ARB_STATUS, 32'h0000_0000);
        rd_chk("arb zero write", lbe_pkg::ADDR_ARB_STATUS, 32'h8F00_0000);
        acc(1'b1, lbe_pkg::ADDR_ARB_STATUS, 32'h0200_0000);
        rd_chk("arb flk clear", lbe_pkg::ADDR_ARB_STATUS, 32'h8D00_0000);
        u_src.arb_ev(2'h2, 1'b1, 32'h0000_0ABC, 1'b0, 1'b0);
        rd_chk("arb master2", lbe_pkg::ADDR_ARB_STATUS, 32'h8DC0_0000);
        acc(1'b1, lbe_pkg::ADDR_ARB_EADDR, 32'hFFFF_FFFF);
        rd_chk("arb addr new", lbe_pkg::ADDR_ARB_EADDR, 32'h0000_0ABC);
        acc(1'b1, lbe_pkg::ADDR_ARB_STATUS, 32'hFFFF_FFFF);
        rd_chk("arb cleared", lbe_pkg::ADDR_ARB_STATUS, 32'h0);
        $display("arbiter error test done");
    endtask

    task automatic t_brg_err();
        u_src.brg_ev(2'h3, lbe_pkg::ERR_TIMEOUT, 1'b0, 32'h4000_0010, 1'b1, 1'b1);
        rd_chk("dma slot", lbe_pkg::ADDR_BRG_STATUS1, 32'h03C0_0000);
        rd_chk("brg addr", lbe_pkg::ADDR_BRG_EADDR, 32'h4000_0010);
        u_src.brg_ev(2'h0, lbe_pkg::ERR_SLAVE, 1'b1, 32'h5000_0020, 1'b0, 1'b0);
        rd_chk("slot0 slave", lbe_pkg::ADDR_BRG_STATUS0, 32'h8000_0000);
        rd_chk("brg addr held", lbe_pkg::ADDR_BRG_EADDR, 32'h4000_0010);
        u_src.brg_ev(2'h3, lbe_pkg::ERR_SLAVE, 1'b1, 32'h6000_0030, 1'b0, 1'b0);
        rd_chk("dma locked", lbe_pkg::ADDR_BRG_STATUS1, 32'h03C0_0000);
        acc(1'b1, lbe_pkg::ADDR_BRG_STATUS1, 32'h0000_0000);
        rd_chk("lock zero write", lbe_pkg::ADDR_BRG_STATUS1, 32'h03C0_0000);
        acc(1'b1, lbe_pkg::ADDR_BRG_STATUS1, 32'h00C0_0000);
        rd_chk("locks released", lbe_pkg::ADDR_BRG_STATUS1, 32'h0300_0000);
        acc(1'b1, lbe_pkg::ADDR_BRG_STATUS0, 32'h8000_0000);
        u_src.brg_ev(2'h1, lbe_pkg::ERR_TIMEOUT, 1'b0, 32'h7000_0040, 1'b0, 1'b0);
        rd_chk("slot1 write", lbe_pkg::ADDR_BRG_STATUS0, 32'h0300_0000);
        acc(1'b1, lbe_pkg::ADDR_BRG_EADDR, 32'h0);
        rd_chk("brg addr new", lbe_pkg::ADDR_BRG_EADDR, 32'h7000_0040);
        $display("bridge error test done");
    endtask

    // ------------------------------------------------------------
    // Hang guard and main sequence
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("[FAIL] %0t run did not finish", $time);
            results();
        end
    end

    initial begin
        {rst_b, dcr_read, dcr_write, dcr_abus, dcr_dbus_in} = '0;
        repeat (3) @(negedge mclk);
        rst_b = 1'b1;
        repeat (3) @(negedge mclk);
        t_reset();
        t_ctrl();
        t_grant();
        t_arb_err();
        t_brg_err();
        results();
    end
endmodule
